/* File: common/region_alias_pkg.sv */
package region_alias_pkg;
    // Register byte offsets (no offsets printed; chosen locally)
    localparam logic [7:0] OFF_REGION_NUMBER = 8'h00;
    localparam logic [7:0] OFF_BASE_PRIMARY  = 8'h04;
    localparam logic [7:0] OFF_ATTR_PRIMARY  = 8'h08;
    localparam logic [7:0] OFF_BASE_ALIAS1   = 8'h0C;
    localparam logic [7:0] OFF_ATTR_ALIAS1   = 8'h10;
    localparam logic [7:0] OFF_BASE_ALIAS2   = 8'h14;
    localparam logic [7:0] OFF_ATTR_ALIAS2   = 8'h18;
    localparam int ADDR_W = 8;

    // Base-address register fields
    localparam int VALID_BIT  = 4;
    localparam int REGION_LSB = 0;
    localparam int REGION_W   = 4;

    // Attribute/size register fields
    localparam int EXEC_NEVER_BIT = 28;
    localparam int AP_LSB         = 24;
    localparam int AP_W           = 3;
    localparam int TEX_LSB        = 19;
    localparam int TEX_W          = 3;
    localparam int SHARE_BIT      = 18;
    localparam int CACHE_BIT      = 17;
    localparam int BUFFER_BIT     = 16;
    localparam int SRD_LSB        = 8;
    localparam int SRD_W          = 8;
    localparam int SIZE_LSB       = 1;
    localparam int SIZE_W         = 5;
    localparam int ENABLE_BIT     = 0;

    // Writable bits of the attribute/size register
    localparam logic [31:0] ATTR_MASK = 32'h173FFF3F;
    localparam logic [4:0]  SIZE_4GB  = 5'h1F;
    localparam logic [31:0] RESET_WORD = 32'h00000000;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/mpu_region_alias_regs.sv */
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module mpu_region_alias_regs #(
    parameter int NUM_REGIONS = 8
) (
    input  wire logic                                      clk_i,
    input  wire logic                                      reset_n_i,
    input  wire logic [region_alias_pkg::ADDR_W-1:0]       s_axi_awaddr_i,
    input  wire logic                                      s_axi_awvalid_i,
    output logic                                           s_axi_awready_o,
    input  wire logic [31:0]                               s_axi_wdata_i,
    input  wire logic [3:0]                                s_axi_wstrb_i,
    input  wire logic                                      s_axi_wvalid_i,
    output logic                                           s_axi_wready_o,
    output logic [1:0]                                     s_axi_bresp_o,
    output logic                                           s_axi_bvalid_o,
    input  wire logic                                      s_axi_bready_i,
    input  wire logic [region_alias_pkg::ADDR_W-1:0]       s_axi_araddr_i,
    input  wire logic                                      s_axi_arvalid_i,
    output logic                                           s_axi_arready_o,
    output logic [31:0]                                    s_axi_rdata_o,
    output logic [1:0]                                     s_axi_rresp_o,
    output logic                                           s_axi_rvalid_o,
    input  wire logic                                      s_axi_rready_i,
    input  wire logic [$clog2(NUM_REGIONS)-1:0]            check_region_i,
    output logic [31:0]                                    region_base_o,
    output logic [31:0]                                    region_limit_o,
    output logic                                           region_enable_o,
    output logic                                           region_exec_never_o,
    output logic [region_alias_pkg::AP_W-1:0]              region_access_perm_o,
    output logic [region_alias_pkg::TEX_W+2:0]             region_mem_type_o,
    output logic [region_alias_pkg::SRD_W-1:0]             region_subregion_on_o
);
    import region_alias_pkg::*;

    localparam int RN_W = $clog2(NUM_REGIONS);

    // The region field is four bits wide, so more regions cannot be addressed
    initial begin
        if (NUM_REGIONS < 2 || NUM_REGIONS > 16 || (NUM_REGIONS & (NUM_REGIONS - 1)) != 0) begin
            $error("NUM_REGIONS must be a power of two from 2 to 16");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Region storage, one entry per region, shared by primary and alias views

    logic [RN_W-1:0]  region_number;
    logic [31:0]      base_store [NUM_REGIONS];
    logic [31:0]      attr_store [NUM_REGIONS];

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data accepted independently, in any order

    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_held;
    logic              wr_fire;
    logic              wr_hit;

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign wr_fire         = aw_held && w_held;

    // Hold the address until the data also arrives
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Hold the data and strobes until the address also arrives
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Decode the latched write address
    always_comb begin
        unique case (aw_addr)
            OFF_REGION_NUMBER, OFF_BASE_PRIMARY, OFF_ATTR_PRIMARY,
            OFF_BASE_ALIAS1, OFF_ATTR_ALIAS1, OFF_BASE_ALIAS2, OFF_ATTR_ALIAS2: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Response: one cycle after both halves are in, held until taken
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register update

    logic            is_base_wr;
    logic            is_attr_wr;
    logic            valid_wr;
    logic [RN_W-1:0] target_region;
    logic [31:0]     strb_mask;

    assign is_base_wr = wr_fire && (aw_addr == OFF_BASE_PRIMARY || aw_addr == OFF_BASE_ALIAS1
                                    || aw_addr == OFF_BASE_ALIAS2);
    assign is_attr_wr = wr_fire && (aw_addr == OFF_ATTR_PRIMARY || aw_addr == OFF_ATTR_ALIAS1
                                    || aw_addr == OFF_ATTR_ALIAS2);
    assign valid_wr   = w_strb[0] && w_data[VALID_BIT];
    // Valid bit redirects the write to the written region, else the current one
    assign target_region = (is_base_wr && valid_wr) ? w_data[REGION_LSB +: RN_W]
                                                    : region_number;
    assign strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    // Region number: direct write or redirect by a valid base write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            region_number <= '0;
        end else if (wr_fire && aw_addr == OFF_REGION_NUMBER && w_strb[0]) begin
            region_number <= w_data[RN_W-1:0];
        end else if (is_base_wr && valid_wr) begin
            region_number <= w_data[REGION_LSB +: RN_W];
        end
    end

    // Per-region storage; low five base bits are never stored (32 B minimum)
    generate
        for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_region
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    base_store[g] <= RESET_WORD;
                    attr_store[g] <= RESET_WORD;
                end else if (target_region == RN_W'(g)) begin
                    if (is_base_wr) begin
                        base_store[g] <= ((base_store[g] & ~strb_mask) | (w_data & strb_mask))
                                         & 32'hFFFFFFE0;
                    end
                    if (is_attr_wr) begin
                        attr_store[g] <= ((attr_store[g] & ~strb_mask) | (w_data & strb_mask))
                                         & ATTR_MASK;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel: answer one cycle after the address is taken

    logic [31:0] rd_word;
    logic [1:0]  rd_resp;
    logic [31:0] cur_base;

    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign cur_base = base_store[region_number];

    // Base reads show the stored address, valid as zero, current region number
    always_comb begin
        rd_word = 32'h00000000;
        rd_resp = RESP_OKAY;
        unique case (s_axi_araddr_i)
            OFF_REGION_NUMBER: rd_word = 32'(region_number);
            OFF_BASE_PRIMARY, OFF_BASE_ALIAS1, OFF_BASE_ALIAS2:
                rd_word = (cur_base & 32'hFFFFFFE0) | 32'(region_number);
            OFF_ATTR_PRIMARY, OFF_ATTR_ALIAS1, OFF_ATTR_ALIAS2:
                rd_word = attr_store[region_number];
            default: rd_resp = RESP_SLVERR;
        endcase
    end

    // Read data registered; held until the master takes it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= rd_resp;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Region view for the access checker

    logic [31:0] sel_attr;
    logic [31:0] sel_base;
    logic [4:0]  sel_size;
    logic [31:0] size_mask;
    logic [31:0] next_base;
    logic [31:0] next_limit;
    logic [7:0]  next_sub_on;

    assign sel_attr = attr_store[check_region_i];
    assign sel_base = base_store[check_region_i];
    assign sel_size = sel_attr[SIZE_LSB +: SIZE_W];

    // Size mask has (SIZE+1) low ones; base keeps bits 31..N with N = SIZE+1
    always_comb begin
        size_mask   = 32'hFFFFFFFF >> (5'd31 - sel_size);
        next_base   = sel_base & ~size_mask;
        next_limit  = next_base | size_mask;
        next_sub_on = ~sel_attr[SRD_LSB +: SRD_W];
        if (sel_size == SIZE_4GB) begin
            next_base  = 32'h00000000;
            next_limit = 32'hFFFFFFFF;
        end
        // Regions of 128 B and less have no subregions; treat all as enabled
        if (sel_size < 5'd7) begin
            next_sub_on = 8'hFF;
        end
    end

    // Outputs registered, so the checker sees one cycle of latency after a write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            region_base_o         <= '0;
            region_limit_o        <= '0;
            region_enable_o       <= 1'b0;
            region_exec_never_o   <= 1'b0;
            region_access_perm_o  <= '0;
            region_mem_type_o     <= '0;
            region_subregion_on_o <= '0;
        end else begin
            region_base_o         <= next_base;
            region_limit_o        <= next_limit;
            region_enable_o       <= sel_attr[ENABLE_BIT];
            region_exec_never_o   <= sel_attr[EXEC_NEVER_BIT];
            region_access_perm_o  <= sel_attr[AP_LSB +: AP_W];
            region_mem_type_o     <= {sel_attr[TEX_LSB +: TEX_W], sel_attr[SHARE_BIT],
                                      sel_attr[CACHE_BIT], sel_attr[BUFFER_BIT]};
            region_subregion_on_o <= next_sub_on;
        end
    end

endmodule

/* File: verif/mpu_region_alias_regs_properties.sv */
`timescale 1ns/1ps
module mpu_region_alias_regs_properties
    import region_alias_pkg::*;
#(
    parameter int NUM_REGIONS = 8
) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [7:0]  s_axi_araddr_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] region_base_o,
    input wire logic [31:0] region_limit_o,
    input wire logic        region_enable_o,
    input wire logic [7:0]  region_subregion_on_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [7:0]  rd_addr;
    logic [31:0] span;
    logic        base_rd;
    // Remember the register a pending read answers for
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) rd_addr <= 8'h00;
        else if (s_axi_arvalid_i && s_axi_arready_o) rd_addr <= s_axi_araddr_i;
    end
    // Span is size minus one only while the base is size aligned
    assign span = region_limit_o ^ region_base_o;
    assign base_rd = rd_addr == OFF_BASE_PRIMARY || rd_addr == OFF_BASE_ALIAS1
        || rd_addr == OFF_BASE_ALIAS2;
    property p_b_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_w_busy;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_w_busy: assert property (p_w_busy) else $error("write taken during response");
    property p_r_busy;
        s_axi_rvalid_o |-> !s_axi_arready_o;
    endproperty
    a_r_busy: assert property (p_r_busy) else $error("read taken during response");
    property p_r_answer;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_w_answer;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
            |-> ##[1:2] s_axi_bvalid_o;
    endproperty
    a_w_answer: assert property (p_w_answer) else $error("write answer late");
    property p_valid_zero;
        s_axi_rvalid_o && base_rd |-> !s_axi_rdata_o[VALID_BIT];
    endproperty
    a_valid_zero: assert property (p_valid_zero) else $error("valid bit read as one");
    property p_unmapped;
        s_axi_rvalid_o && rd_addr > OFF_ATTR_ALIAS2
            |-> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_span;
        (span & (span + 32'h00000001)) == 32'h00000000 && region_base_o[4:0] == 5'h00;
    endproperty
    a_span: assert property (p_span) else $error("region span not a power of two");
    property p_small;
        region_enable_o && span < 32'h000000FF |-> region_subregion_on_o == 8'hFF;
    endproperty
    a_small: assert property (p_small) else $error("small region lost subregions");
endmodule

bind mpu_region_alias_regs mpu_region_alias_regs_properties #(.NUM_REGIONS(NUM_REGIONS)) u_props (.*);

/* File: verif/region_fetch_model.sv */
`timescale 1ns/1ps
module region_fetch_model (
    input  wire logic [2:0]  want_region_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] base_i,
    input  wire logic [31:0] limit_i,
    input  wire logic        enable_i,
    input  wire logic        exec_never_i,
    output logic [2:0]       check_region_o,
    output logic             fetch_ok_o
);
    // The core names the region it probes; no latency on this side
    assign check_region_o = want_region_i;
    // Fetch allowed inside an enabled region only when execute-never is clear
    assign fetch_ok_o = enable_i && !exec_never_i && addr_i >= base_i
        && addr_i <= limit_i;
endmodule

/* File: verif/mpu_region_alias_regs_test.sv */
`timescale 1ns/1ps
module mpu_region_alias_regs_test;
    import region_alias_pkg::*;
    typedef struct {
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic [7:0]  ra;
        logic [31:0] rx;
        logic [1:0]  rs;
    } row_t;
    logic clk_i = 0, reset_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
    logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, probe = 32'h00020000, got;
    logic [3:0]  s_axi_wstrb_i = 4'h0;
    logic [2:0]  want = 3'h3;
    logic [1:0]  resp;
    wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire region_enable_o, region_exec_never_o, fetch_ok;
    wire [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    wire [31:0] s_axi_rdata_o, region_base_o, region_limit_o;
    wire [2:0]  check_region_i, region_access_perm_o;
    wire [5:0]  region_mem_type_o;
    wire [7:0]  region_subregion_on_o;
    int num_errors = 0, n_checks = 0;
    // Write then read back, often through a different alias of the same register
    row_t rows [6] = '{
        '{OFF_BASE_ALIAS1, 32'h00010013, 4'hF, OFF_BASE_ALIAS1, 32'h00010003, RESP_OKAY},
        '{OFF_BASE_ALIAS2, 32'h00020005, 4'hF, OFF_BASE_PRIMARY, 32'h00020003, RESP_OKAY},
        '{OFF_ATTR_ALIAS1, 32'h1203A413, 4'hF, OFF_ATTR_ALIAS2, 32'h1203A413, RESP_OKAY},
        '{OFF_ATTR_ALIAS2, 32'hFFFF0000, 4'hC, OFF_ATTR_PRIMARY, 32'h173FA413, RESP_OKAY},
        '{OFF_ATTR_PRIMARY, 32'h1203A413, 4'hF, OFF_ATTR_ALIAS1, 32'h1203A413, RESP_OKAY},
        '{8'h1C, 32'hFFFFFFFF, 4'hF, 8'h1C, 32'h00000000, RESP_SLVERR}
    };
    mpu_region_alias_regs #(.NUM_REGIONS(8)) DUT (.*);
    region_fetch_model u_core (.want_region_i(want), .addr_i(probe),
        .base_i(region_base_o), .limit_i(region_limit_o), .enable_i(region_enable_o),
        .exec_never_i(region_exec_never_o), .check_region_o(check_region_i),
        .fetch_ok_o(fetch_ok));
    always #50 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic limit_hit(input int n);
        if (n == 50) begin
            num_errors++;
            conclude();
        end
    endtask
    // Ready is read before the edge's own updates land, so hand-off stays exact
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 0;
            if (s_axi_bvalid_o && !s_axi_awvalid_i && !s_axi_wvalid_i) break;
        end
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 0;
        limit_hit(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 0;
            if (s_axi_rvalid_o && !s_axi_arvalid_i) break;
        end
        got = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        s_axi_rready_i <= 0;
        limit_hit(n);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1;
        rd(OFF_ATTR_PRIMARY);
        check("attr after reset", got, 32'h00000000);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd, rows[i].ws);
            check("bresp", {30'h0, resp}, {30'h0, rows[i].rs});
            rd(rows[i].ra);
            check("rdata", got, rows[i].rx);
            check("rresp", {30'h0, resp}, {30'h0, rows[i].rs});
        end
        // Region 3 is 1 KB at 0x20000, execute-never set
        repeat (2) @(posedge clk_i);
        check("base", region_base_o, 32'h00020000);
        check("limit", region_limit_o, 32'h000203FF);
        check("attrs", {21'h0, region_enable_o, region_exec_never_o, region_access_perm_o,
            region_mem_type_o}, 32'h00000683);
        check("subregions", {24'h0, region_subregion_on_o}, 32'h0000005B);
        check("fetch blocked", {31'h0, fetch_ok}, 32'h00000000);
        wr(OFF_ATTR_ALIAS2, 32'h0000003F, 4'hF);
        repeat (2) @(posedge clk_i);
        check("4g base", region_base_o, 32'h00000000);
        check("4g limit", region_limit_o, 32'hFFFFFFFF);
        check("fetch open", {31'h0, fetch_ok}, 32'h00000001);
        // Small region: software keeps the disable field at zero
        wr(OFF_ATTR_ALIAS1, 32'h0000000B, 4'hF);
        repeat (2) @(posedge clk_i);
        check("small subregions", {24'h0, region_subregion_on_o}, 32'h000000FF);
        reset_n_i <= 0;
        @(posedge clk_i);
        reset_n_i <= 1;
        rd(OFF_BASE_ALIAS1);
        check("base after reset", got, 32'h00000000);
        conclude();
    end
endmodule
